// >>> pkg/rtc_link_pkg.sv
// constants shared by the rtc serial device end and its host controller end
// assumes one 40 MHz system clock on both ends
package rtc_link_pkg;

	// ****************************************
	// clock and link timing
	// ****************************************
	localparam int CLK_HZ        = 40_000_000;
	localparam int SCK_HALF_NS   = 500;
	localparam int SCK_HALF_CYC  = (SCK_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int SEC_CYCLES    = CLK_HZ;
	// one trim step moves one corrected second by 1/16384 s
	localparam int TRIM_DIV      = 16384;
	localparam int TRIM_STEP_CYC = CLK_HZ / TRIM_DIV;
	localparam int PERIODS_COARSE = 20;
	localparam int PERIODS_FINE   = 60;

	// ****************************************
	// command byte: fixed code, register select, direction
	// ****************************************
	localparam logic [3:0] CMD_FIXED    = 4'h6;
	localparam logic [2:0] SEL_STATUS1  = 3'h0;
	localparam logic [2:0] SEL_STATUS2  = 3'h1;
	localparam logic [2:0] SEL_INT1     = 3'h4;
	localparam logic [2:0] SEL_INT2     = 3'h5;
	localparam logic [2:0] SEL_TRIM     = 3'h6;
	localparam int         CMD_BITS     = 8;

	// ****************************************
	// device register fields and reset values
	// ****************************************
	localparam int         ST1_POWER_ON_BIT  = 0;
	localparam int         ST1_RESET_BIT     = 7;
	localparam int         ST2_ALARM1_BIT    = 0;
	localparam int         ST2_FREQ1_BIT     = 1;
	localparam int         ST2_ALARM2_BIT    = 2;
	localparam int         TRIM_RES_BIT      = 0;
	localparam logic [7:0] ST1_RESET_VAL     = 8'h01;
	localparam logic [7:0] ST2_RESET_VAL     = 8'h00;
	localparam logic [7:0] TRIM_RESET_VAL    = 8'h00;

	// ****************************************
	// host controller registers
	// ****************************************
	localparam logic [4:0] HOST_CTRL     = 5'h00;
	localparam logic [4:0] HOST_TXDATA   = 5'h04;
	localparam logic [4:0] HOST_RXDATA   = 5'h08;
	localparam logic [4:0] HOST_IRQ_STAT = 5'h0c;
	localparam logic [4:0] HOST_IRQ_MASK = 5'h10;
	localparam int         CTRL_SEL_LSB  = 0;
	localparam int         CTRL_RW_BIT   = 3;
	localparam int         CTRL_LEN_LSB  = 4;
	localparam int         IRQ_DONE_BIT  = 0;

endpackage : rtc_link_pkg

// >>> pkg/rtc_link_if.sv
// three-wire link between the rtc device end and the host end
// assumes a pull-up on the data line: undriven it reads one
`timescale 1ns/1ps
interface rtc_link_if;
	logic cs;
	logic sck;
	logic dev_sdl_o;
	logic dev_sdl_oe_n;
	logic host_sdl_o;
	logic host_sdl_oe_n;
	logic serial_data_line;

	assign serial_data_line = !dev_sdl_oe_n  ? dev_sdl_o :
	                          !host_sdl_oe_n ? host_sdl_o : 1'b1;

	modport device (input cs, input sck, input serial_data_line,
	                output dev_sdl_o, output dev_sdl_oe_n);
	modport host   (input serial_data_line,
	                output cs, output sck, output host_sdl_o, output host_sdl_oe_n);
endinterface : rtc_link_if

// >>> rtl/rtc_device.sv
// rtc device end: serial register access and trimmed 1 Hz time base
// assumes link pins synchronous to clk_sys and the host keeping its side
// What this block does
// - host shifts on fall, device samples on rise
// - eighth captured bit selects read or write
// - read data driven, updated each falling edge
// - write data stored into selected register
// - under eight clocks, nothing is processed
// - host clocks exactly the register's bit count
// - select bit picks status one or two
// - host sets status two before interrupt one
// - interrupt one three bytes in alarm mode
// - interrupt one holds frequency in frequency mode
// - interrupt two three bytes when enable set
// - interrupt two never sets output frequency
// - resolution bit picks coarse or fine step
// - bit-reversed signed count in upper seven bits
// - trim touches only the divided time base
// - one period in twenty or sixty differs
// - power-up sets flag, 1 Hz on interrupt
// - host writes zero when trim unwanted
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module rtc_device #(
	parameter int SEC_CYCLES    = rtc_link_pkg::SEC_CYCLES,
	parameter int TRIM_STEP_CYC = rtc_link_pkg::TRIM_STEP_CYC
) (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	rtc_link_if.device        link,
	output logic              int_n,
	output logic              second_pulse,
	output logic [7:0]        freq_select,
	output logic              power_on_flag
);

	typedef enum logic [2:0] {IDLE, CMD, RD, WR, SKIP} dev_state_e;

	// ****************************************
	// register length and select check helpers
	// ****************************************
	function automatic logic [1:0] reg_bytes(input logic [2:0] sel, input logic [7:0] st2);
		reg_bytes = 2'd1;
		if (sel == rtc_link_pkg::SEL_INT1 && st2[rtc_link_pkg::ST2_ALARM1_BIT]
		    && !st2[rtc_link_pkg::ST2_FREQ1_BIT])
			reg_bytes = 2'd3;
		else if (sel == rtc_link_pkg::SEL_INT2 && st2[rtc_link_pkg::ST2_ALARM2_BIT])
			reg_bytes = 2'd3;
	endfunction : reg_bytes

	function automatic logic known_sel(input logic [2:0] sel);
		known_sel = sel == rtc_link_pkg::SEL_STATUS1 || sel == rtc_link_pkg::SEL_STATUS2 ||
		            sel == rtc_link_pkg::SEL_INT1 || sel == rtc_link_pkg::SEL_INT2 ||
		            sel == rtc_link_pkg::SEL_TRIM;
	endfunction : known_sel

	dev_state_e  state_q;
	logic        sck_q;
	logic [7:0]  cmd_q;
	logic [4:0]  bit_cnt_q;
	logic [4:0]  data_bits_q;
	logic [23:0] shift_q;
	logic        sdl_o_q;
	logic        sdl_oe_n_q;
	logic [7:0]  status1_q;
	logic [7:0]  status2_q;
	logic [23:0] int1_q;
	logic [23:0] int2_q;
	logic [7:0]  trim_q;

	wire logic       sck_rise = link.sck & ~sck_q;
	wire logic       sck_fall = ~link.sck & sck_q;
	wire logic [7:0] cmd_next = {cmd_q[6:0], link.serial_data_line};
	wire logic [2:0] sel_next = cmd_next[3:1];
	wire logic [2:0] sel      = cmd_q[3:1];
	wire logic [1:0] len_next = reg_bytes(sel_next, status2_q);
	wire logic [1:0] len_cur  = reg_bytes(sel, status2_q);
	wire logic [23:0] wr_val  = (len_cur == 2'd3) ? shift_q : {16'h0000, shift_q[23:16]};
	wire logic       wr_last  = (state_q == WR) && sck_rise && (bit_cnt_q == data_bits_q - 5'd1);
	wire logic [7:0] wr_byte  = shift_q[23:16];

	logic [23:0] rd_val;
	always_comb begin
		rd_val = 24'h000000;
		if (sel_next == rtc_link_pkg::SEL_STATUS1)
			rd_val = {16'h0000, status1_q};
		else if (sel_next == rtc_link_pkg::SEL_STATUS2)
			rd_val = {16'h0000, status2_q};
		else if (sel_next == rtc_link_pkg::SEL_INT1)
			rd_val = int1_q;
		else if (sel_next == rtc_link_pkg::SEL_INT2)
			rd_val = int2_q;
		else if (sel_next == rtc_link_pkg::SEL_TRIM)
			rd_val = {16'h0000, trim_q};
	end

	// ****************************************
	// serial transfer engine
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			sck_q <= 1'b1;
		else
			sck_q <= link.sck;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q     <= IDLE;
			cmd_q       <= 8'h00;
			bit_cnt_q   <= 5'd0;
			data_bits_q <= 5'd0;
			shift_q     <= 24'h000000;
			sdl_o_q     <= 1'b1;
			sdl_oe_n_q  <= 1'b1;
		end else if (!link.cs) begin
			// a dropped select leaves nothing half done
			state_q    <= IDLE;
			bit_cnt_q  <= 5'd0;
			sdl_oe_n_q <= 1'b1;
		end else begin
			case (state_q)
				IDLE: begin
					state_q <= CMD;
				end
				CMD: begin
					if (sck_rise) begin
						cmd_q     <= cmd_next;
						bit_cnt_q <= bit_cnt_q + 5'd1;
						// fewer than eight rises: keep waiting
						if (bit_cnt_q == 5'(rtc_link_pkg::CMD_BITS - 1)) begin
							bit_cnt_q   <= 5'd0;
							data_bits_q <= {len_next, 3'b000};
							shift_q     <= rd_val;
							if (cmd_next[7:4] != rtc_link_pkg::CMD_FIXED || !known_sel(sel_next))
								state_q <= SKIP;
							else if (cmd_next[0])
								state_q <= RD;
							else
								state_q <= WR;
						end
					end
				end
				RD: begin
					if (sck_fall) begin
						if (bit_cnt_q == data_bits_q) begin
							sdl_oe_n_q <= 1'b1;
						end else begin
							sdl_o_q    <= shift_q[0];
							sdl_oe_n_q <= 1'b0;
							shift_q    <= {1'b0, shift_q[23:1]};
							bit_cnt_q  <= bit_cnt_q + 5'd1;
						end
					end
				end
				WR: begin
					if (sck_rise) begin
						shift_q   <= {link.serial_data_line, shift_q[23:1]};
						bit_cnt_q <= bit_cnt_q + 5'd1;
						if (wr_last)
							state_q <= SKIP;
					end
				end
				default: begin
					state_q <= SKIP;
				end
			endcase
		end
	end

	// ****************************************
	// device registers
	// ****************************************
	// commit only once the full length has arrived, so a short write changes nothing
	wire logic [23:0] wr_full = (len_cur == 2'd3) ? {link.serial_data_line, shift_q[23:1]}
	                                              : {16'h0000, link.serial_data_line, wr_byte[7:1]};
	wire logic        wr_st1  = wr_last && sel == rtc_link_pkg::SEL_STATUS1;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			status1_q <= rtc_link_pkg::ST1_RESET_VAL;
			status2_q <= rtc_link_pkg::ST2_RESET_VAL;
			int1_q    <= 24'h000000;
			int2_q    <= 24'h000000;
			trim_q    <= rtc_link_pkg::TRIM_RESET_VAL;
		end else if (wr_last) begin
			if (sel == rtc_link_pkg::SEL_STATUS1 && wr_full[rtc_link_pkg::ST1_RESET_BIT])
				status1_q <= 8'h00;
			else if (sel == rtc_link_pkg::SEL_STATUS2)
				status2_q <= wr_full[7:0];
			else if (sel == rtc_link_pkg::SEL_INT1)
				int1_q <= wr_full;
			else if (sel == rtc_link_pkg::SEL_INT2)
				int2_q <= wr_full;
			else if (sel == rtc_link_pkg::SEL_TRIM)
				trim_q <= wr_full[7:0];
		end
	end

	// ****************************************
	// trimmed 1 Hz time base
	// ****************************************
	function automatic logic [6:0] trim_count(input logic [7:0] t);
		for (int i = 0; i < 7; i++)
			trim_count[i] = t[7 - i];
	endfunction : trim_count

	logic [31:0] sec_cnt_q;
	logic [5:0]  per_cnt_q;
	logic        int_n_q;
	logic        pulse_q;

	wire logic        fine      = trim_q[rtc_link_pkg::TRIM_RES_BIT];
	wire logic [5:0]  per_last  = fine ? 6'(rtc_link_pkg::PERIODS_FINE - 1)
	                                   : 6'(rtc_link_pkg::PERIODS_COARSE - 1);
	// positive count shortens the odd period, negative lengthens it
	wire logic signed [31:0] adj = 32'(signed'(trim_count(trim_q))) * 32'(TRIM_STEP_CYC);
	wire logic        odd_per   = per_cnt_q >= per_last;
	// the oscillator and its 32 kHz output are never touched, only this count
	wire logic [31:0] per_len   = odd_per ? 32'(SEC_CYCLES) - 32'(adj) : 32'(SEC_CYCLES);
	wire logic        sec_end   = sec_cnt_q >= per_len - 32'd1;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sec_cnt_q <= 32'd0;
			per_cnt_q <= 6'd0;
			int_n_q   <= 1'b1;
			pulse_q   <= 1'b0;
		end else begin
			sec_cnt_q <= sec_end ? 32'd0 : sec_cnt_q + 32'd1;
			pulse_q   <= sec_end;
			if (sec_end)
				per_cnt_q <= odd_per ? 6'd0 : per_cnt_q + 6'd1;
			// low half of each second while the power-on flag stands
			int_n_q <= !(status1_q[rtc_link_pkg::ST1_POWER_ON_BIT]
			             && sec_cnt_q < {1'b0, per_len[31:1]});
		end
	end

	// frequency setting only ever comes from interrupt one
	logic [7:0] freq_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			freq_q <= 8'h00;
		else
			freq_q <= status2_q[rtc_link_pkg::ST2_FREQ1_BIT] ? int1_q[7:0] : 8'h00;
	end

	logic pof_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			pof_q <= 1'b1;
		else
			pof_q <= wr_st1 ? pof_q & ~wr_full[rtc_link_pkg::ST1_RESET_BIT]
			                : status1_q[rtc_link_pkg::ST1_POWER_ON_BIT];
	end

	assign link.dev_sdl_o    = sdl_o_q;
	assign link.dev_sdl_oe_n = sdl_oe_n_q;
	assign int_n             = int_n_q;
	assign second_pulse      = pulse_q;
	assign freq_select       = freq_q;
	assign power_on_flag     = pof_q;

endmodule : rtc_device

// >>> rtl/rtc_host.sv
// host controller end: runs one serial transfer per software order
// assumes a simple register port and the device end on the same clock
`timescale 1ns/1ps
module rtc_host (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	rtc_link_if.host         link,
	input  wire logic [4:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	output logic             irq
);

	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END} host_state_e;

	host_state_e state_q;
	logic [7:0]  timer_q;
	logic [4:0]  bit_q;
	logic [4:0]  total_q;
	logic [7:0]  cmd_q;
	logic        rw_q;
	logic [1:0]  len_q;
	logic [23:0] tx_q;
	logic [23:0] rx_q;
	logic [23:0] rxdata_q;
	logic        cs_q;
	logic        sck_q;
	logic        sdl_o_q;
	logic        sdl_oe_n_q;
	logic        stat_q;
	logic        mask_q;
	logic [31:0] rdata_q;
	logic        irq_q;

	// ****************************************
	// register port decode
	// ****************************************
	wire logic       busy     = state_q != H_IDLE;
	wire logic       wr_ctrl  = wr && addr == rtc_link_pkg::HOST_CTRL;
	wire logic [1:0] len_in   = wdata[rtc_link_pkg::CTRL_LEN_LSB +: 2];
	// orders while busy, or with a zero length, are dropped
	wire logic       start    = wr_ctrl && !busy && len_in != 2'd0;
	wire logic       half_end = timer_q == 8'(rtc_link_pkg::SCK_HALF_CYC - 1);
	wire logic       done     = state_q == H_END && half_end;
	wire logic       stat_d   = done | (stat_q & ~(wr && addr == rtc_link_pkg::HOST_IRQ_STAT
	                                     && wdata[rtc_link_pkg::IRQ_DONE_BIT]));
	wire logic       mask_d   = (wr && addr == rtc_link_pkg::HOST_IRQ_MASK)
	                            ? wdata[rtc_link_pkg::IRQ_DONE_BIT] : mask_q;
	wire logic       rx_phase = rw_q && bit_q >= 5'(rtc_link_pkg::CMD_BITS);

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		if (addr == rtc_link_pkg::HOST_CTRL)
			rd_mux = {31'h00000000, busy};
		else if (addr == rtc_link_pkg::HOST_TXDATA)
			rd_mux = {8'h00, tx_q};
		else if (addr == rtc_link_pkg::HOST_RXDATA)
			rd_mux = {8'h00, rxdata_q};
		else if (addr == rtc_link_pkg::HOST_IRQ_STAT)
			rd_mux = {31'h00000000, stat_q};
		else if (addr == rtc_link_pkg::HOST_IRQ_MASK)
			rd_mux = {31'h00000000, mask_q};
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 32'h00000000;
			stat_q  <= 1'b0;
			mask_q  <= 1'b0;
			irq_q   <= 1'b0;
		end else begin
			rdata_q <= rd ? rd_mux : 32'h00000000;
			stat_q  <= stat_d;
			mask_q  <= mask_d;
			irq_q   <= stat_d & mask_d;
		end
	end

	// ****************************************
	// serial sequencer
	// ****************************************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q    <= H_IDLE;
			timer_q    <= 8'd0;
			bit_q      <= 5'd0;
			total_q    <= 5'd0;
			cmd_q      <= 8'h00;
			rw_q       <= 1'b0;
			len_q      <= 2'd1;
			tx_q       <= 24'h000000;
			rx_q       <= 24'h000000;
			rxdata_q   <= 24'h000000;
			cs_q       <= 1'b0;
			sck_q      <= 1'b1;
			sdl_o_q    <= 1'b1;
			sdl_oe_n_q <= 1'b1;
		end else begin
			timer_q <= (state_q == H_IDLE || half_end) ? 8'd0 : timer_q + 8'd1;
			if (wr && addr == rtc_link_pkg::HOST_TXDATA && !busy)
				tx_q <= wdata[23:0];
			case (state_q)
				H_IDLE: begin
					if (start) begin
						// software sets status two and enables before touching
						// interrupt registers, and writes zero trim when unwanted
						cmd_q   <= {rtc_link_pkg::CMD_FIXED,
						            wdata[rtc_link_pkg::CTRL_SEL_LSB +: 3],
						            wdata[rtc_link_pkg::CTRL_RW_BIT]};
						rw_q    <= wdata[rtc_link_pkg::CTRL_RW_BIT];
						len_q   <= len_in;
						total_q <= 5'(rtc_link_pkg::CMD_BITS) + {len_in, 3'b000};
						bit_q   <= 5'd0;
						cs_q    <= 1'b1;
						state_q <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (half_end)
						state_q <= H_LOW;
				end
				H_LOW: begin
					if (timer_q == 8'd0) begin
						// shift on the falling edge, device samples on the rise
						sck_q <= 1'b0;
						if (bit_q < 5'(rtc_link_pkg::CMD_BITS)) begin
							sdl_o_q    <= cmd_q[7 - bit_q[2:0]];
							sdl_oe_n_q <= 1'b0;
						end else if (!rw_q) begin
							sdl_o_q    <= tx_q[bit_q - 5'(rtc_link_pkg::CMD_BITS)];
							sdl_oe_n_q <= 1'b0;
						end else begin
							sdl_oe_n_q <= 1'b1;
						end
					end
					if (half_end)
						state_q <= H_HIGH;
				end
				H_HIGH: begin
					if (timer_q == 8'd0) begin
						sck_q <= 1'b1;
						if (rx_phase)
							rx_q <= {link.serial_data_line, rx_q[23:1]};
					end
					if (half_end) begin
						bit_q   <= bit_q + 5'd1;
						state_q <= (bit_q == total_q - 5'd1) ? H_END : H_LOW;
					end
				end
				default: begin
					sdl_oe_n_q <= 1'b1;
					if (half_end) begin
						cs_q     <= 1'b0;
						state_q  <= H_IDLE;
						rxdata_q <= (len_q == 2'd3) ? rx_q
						          : (len_q == 2'd2) ? {8'h00, rx_q[23:8]} : {16'h0000, rx_q[23:16]};
					end
				end
			endcase
		end
	end

	assign link.cs            = cs_q;
	assign link.sck           = sck_q;
	assign link.host_sdl_o    = sdl_o_q;
	assign link.host_sdl_oe_n = sdl_oe_n_q;
	assign rdata              = rdata_q;
	assign irq                = irq_q;

endmodule : rtc_host

// >>> dv/rtc_serial_access_and_clock_trim_properties.sv
// link checker: host and device ends watched on the shared three-wire link
// assumes one clock and instantiation beside the link interface
`timescale 1ns/1ps
module rtc_serial_access_and_clock_trim_properties (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic cs,
	input wire logic sck,
	input wire logic dev_sdl_o,
	input wire logic dev_sdl_oe_n,
	input wire logic host_sdl_o,
	input wire logic host_sdl_oe_n,
	input wire logic serial_data_line
);
	// ****************************************
	// rising-edge count and captured command byte
	// ****************************************
	logic [5:0] rise_cnt_q;
	logic [7:0] cmd_q;
	logic       sck_q;
	wire        sck_rise = sck & ~sck_q;
	wire        sel_ok   = cmd_q[3:1] inside {3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
	wire        code_ok  = (cmd_q[7:4] == rtc_link_pkg::CMD_FIXED) && sel_ok;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rise_cnt_q <= 6'h00;
			cmd_q <= 8'h00;
			sck_q <= 1'b1;
		end else begin
			sck_q <= sck;
			if (!cs)
				rise_cnt_q <= 6'h00;
			else if (sck_rise && rise_cnt_q != 6'h3f)
				rise_cnt_q <= rise_cnt_q + 6'h01;
			if (cs && sck_rise && rise_cnt_q < 6'h08)
				cmd_q <= {cmd_q[6:0], serial_data_line};
		end
	end

	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_sck_idle_high: assert property (!cs |-> sck)
		else $error("shift clock low outside a frame");
	a_host_fall_shift: assert property (cs && !host_sdl_oe_n && !$past(host_sdl_oe_n)
		&& $changed(host_sdl_o) |-> !sck)
		else $error("host data changed while shift clock high");
	a_single_driver: assert property (!(!dev_sdl_oe_n && !host_sdl_oe_n))
		else $error("both ends drive the data line");
	a_read_dir_only: assert property (!dev_sdl_oe_n |-> rise_cnt_q >= 6'h08 && cmd_q[0])
		else $error("device drives without a read command");
	a_wait_eight: assert property (cs && rise_cnt_q < 6'h08 |-> dev_sdl_oe_n)
		else $error("device drives before eight clocks");
	a_valid_select: assert property (!dev_sdl_oe_n |-> code_ok)
		else $error("device answers an invalid command");
	a_hold_on_rise: assert property ($rose(sck) && !dev_sdl_oe_n |-> $stable(dev_sdl_o))
		else $error("device data moved at a rising edge");
	a_dev_fall_shift: assert property ($changed(dev_sdl_o) && !dev_sdl_oe_n
		&& !$past(dev_sdl_oe_n) |-> !sck && !$past(sck))
		else $error("device data changed outside the low phase");
	a_bit_limit: assert property (!dev_sdl_oe_n |-> rise_cnt_q <= 6'd32)
		else $error("device drives past three bytes");
	a_cs_release: assert property ($fell(cs) |-> ##2 dev_sdl_oe_n)
		else $error("data line held after chip select low");

	c_frame: cover property ($rose(cs));
	c_read_bit: cover property ($rose(sck) && !dev_sdl_oe_n);
	c_long_frame: cover property ($fell(cs) && rise_cnt_q == 6'd32);
endmodule : rtc_serial_access_and_clock_trim_properties

// >>> dv/rtc_serial_access_and_clock_trim_tb_top.sv
// bench: host register port drives transfers to the device end, model compares
// assumes a shortened second so trim periods fit in a short run
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
	$display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module rtc_serial_access_and_clock_trim_tb_top;
	localparam int SEC  = 500;
	localparam int STEP = 2;
	logic        clk_sys;
	logic        resetn;
	logic [4:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        irq;
	logic        int_n;
	logic        second_pulse;
	logic [7:0]  freq_select;
	logic        power_on_flag;
	logic        irq_on;
	int          miscompares;
	int          tests_run;
	int          model [8];

	rtc_link_if link ();
	rtc_device #(.SEC_CYCLES(SEC), .TRIM_STEP_CYC(STEP)) i_rtc_device (.clk_sys(clk_sys),
		.resetn(resetn), .link(link.device), .int_n(int_n), .second_pulse(second_pulse),
		.freq_select(freq_select), .power_on_flag(power_on_flag));
	rtc_host i_rtc_host (.clk_sys(clk_sys), .resetn(resetn), .link(link.host), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
	rtc_serial_access_and_clock_trim_properties i_props (.clk_sys(clk_sys), .resetn(resetn),
		.cs(link.cs), .sck(link.sck), .dev_sdl_o(link.dev_sdl_o),
		.dev_sdl_oe_n(link.dev_sdl_oe_n), .host_sdl_o(link.host_sdl_o),
		.host_sdl_oe_n(link.host_sdl_oe_n), .serial_data_line(link.serial_data_line));

	always #12.5 clk_sys = ~clk_sys;

	// ****************************************
	// model and bus tasks
	// ****************************************
	function automatic int req_len(int sel);
		int s2;
		s2 = model[1];
		if (sel == 4 && s2[0] && !s2[1])
			return 3;
		if (sel == 5 && s2[2])
			return 3;
		return 1;
	endfunction : req_len

	task automatic complete_run();
		$display("compared %0d, mismatched %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	// one transfer; the model stores only full-length writes to valid selects
	task automatic run(input int sel, input int rw, input int len, input int d);
		logic [31:0] r;
		int n;
		int m;
		m = (1 << (8 * len)) - 1;
		wr_reg(rtc_link_pkg::HOST_TXDATA, 32'(d));
		wr_reg(rtc_link_pkg::HOST_CTRL, 32'((len << 4) | (rw << 3) | sel));
		r = 32'h0;
		n = 0;
		while (r[0] !== 1'b1) begin
			rd_reg(rtc_link_pkg::HOST_IRQ_STAT, r);
			n++;
			if (n > 2000) begin
				miscompares++;
				complete_run();
			end
		end
		`CHK(irq, irq_on)
		rd_reg(rtc_link_pkg::HOST_RXDATA, r);
		wr_reg(rtc_link_pkg::HOST_IRQ_STAT, 32'h1);
		@(posedge clk_sys);
		#1;
		`CHK(irq, 1'b0)
		if (rw == 1) begin
			`CHK(r & 32'(m), 32'((sel inside {0, 1, 4, 5, 6}) ? model[sel] & m : m))
		end else if (sel == 0 && len == 1) begin
			// status one only reacts to its clear bit
			if (d & 'h80)
				model[0] = 0;
		end else if (sel inside {1, 4, 5, 6} && len == req_len(sel))
			model[sel] = d & m;
	endtask : run

	task automatic wait_pulse(output int c);
		c = 0;
		do begin
			@(posedge clk_sys);
			#1;
			c++;
			if (c > 2 * SEC) begin
				miscompares++;
				complete_run();
			end
		end while (second_pulse !== 1'b1);
	endtask : wait_pulse

	// exactly one odd period is expected in any n whole periods when trim is set
	task automatic meas(input int n, input int exp_len);
		int c;
		int odd;
		int olen;
		odd = 0;
		olen = 0;
		wait_pulse(c);
		for (int i = 0; i < n; i++) begin
			wait_pulse(c);
			if (c != SEC) begin
				odd++;
				olen = c;
			end
		end
		`CHK(odd, (exp_len != SEC) ? 1 : 0)
		if (odd == 1)
			`CHK(olen, exp_len)
	endtask : meas

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int d;
		int f;
		int cnt;
		int tv;
		logic [31:0] r;
		clk_sys = 1'b0;
		resetn = 1'b0;
		addr = 5'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		irq_on = 1'b1;
		miscompares = 0;
		tests_run = 0;
		model = '{1, 0, 0, 0, 0, 0, 0, 0};
		void'($urandom(32'hdf0b));
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK(power_on_flag, 1'b1)
		wait_pulse(d);
		// low half starts the cycle after the second pulse
		@(posedge clk_sys);
		#1;
		`CHK(int_n, 1'b0)
		wr_reg(rtc_link_pkg::HOST_IRQ_MASK, 32'h1);
		run(0, 1, 1, 0);
		run(1, 1, 1, 0);
		run(6, 1, 1, 0);
		run(2, 1, 1, 0);
		$display("test reset values done");
		f = $urandom;
		d = $urandom;
		run(1, 0, 1, 2);
		run(4, 0, 1, f);
		`CHK(freq_select, f[7:0])
		run(1, 0, 1, 1);
		run(4, 0, 1, d);
		run(4, 1, 3, 0);
		run(4, 0, 3, d);
		run(4, 1, 3, 0);
		`CHK(freq_select, 8'h00)
		run(1, 0, 1, 6);
		run(4, 0, 1, f);
		run(5, 0, 3, d ^ f);
		run(5, 1, 3, 0);
		`CHK(freq_select, f[7:0])
		$display("test interrupt registers done");
		wr_reg(rtc_link_pkg::HOST_IRQ_MASK, 32'h0);
		irq_on = 1'b0;
		run(1, 1, 1, 0);
		wr_reg(rtc_link_pkg::HOST_IRQ_MASK, 32'h1);
		irq_on = 1'b1;
		rd_reg(5'h14, r);
		`CHK(r, 32'h0)
		run(0, 0, 1, 8'h80);
		`CHK(power_on_flag, 1'b0)
		run(0, 1, 1, 0);
		$display("test host port done");
		for (int k = 0; k < 3; k++) begin
			cnt = (k == 2) ? 0 : ($urandom % 127) + 1;
			tv = k % 2;
			for (int b = 0; b < 7; b++)
				tv[7 - b] = cnt[b];
			run(6, 0, 1, tv);
			run(6, 1, 1, 0);
			meas((k == 1) ? 60 : 20, SEC - ((cnt > 63) ? cnt - 128 : cnt) * STEP);
			$display("test trim step %0d done", k);
		end
		complete_run();
	end
endmodule : rtc_serial_access_and_clock_trim_tb_top
